// ### core/input_sync.sv
// two-flop synchroniser for a bundle of comparator levels
`timescale 1ns/1ns
`default_nettype none
module input_sync (
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    input  wire logic [fault_supervisor_pkg::SYNC_WIDTH-1:0] asyncIn,
    output var  logic [fault_supervisor_pkg::SYNC_WIDTH-1:0] syncOut
);
    logic [fault_supervisor_pkg::SYNC_WIDTH-1:0] stage1_reg;

    // stage1 is read only by the second flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= fault_supervisor_pkg::SYNC_RESET;
            syncOut    <= fault_supervisor_pkg::SYNC_RESET;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// ### core/led_driver_fault_supervisor.sv
// fault supervision state machine for the buck-boost led driver
`timescale 1ns/1ns
`default_nettype none
// How it works
// - while idle only overtemperature is reported; gate-supply and enable undervoltage keep it idle
// - short declared after sense below short threshold for 8 cycles
// - short and open-load detection ignored until soft start reaches blanking level
// - short: short flag low, other flag high, gates low, gate supply on
// - short clears: rerun full soft start
// - output overvoltage: open/ov flag low, short flag high, gates low, supply on
// - output overvoltage gone: restart through soft start, release open/ov flag
// - open load needs feedback above rise threshold and low current together
// - open-load detection suppressed while soft start below blanking level
// - after open load restart through soft start; other faults may coexist
// - compensation node held discharged while open load persists
// - input overvoltage: open/ov flag low, short flag high, soft start discharged
// - input overvoltage gone: restart through soft start, release flag
// - overtemperature: both flags low, gates low, supply off, top priority
// - after overtemperature clears, start again through soft start
// - gates off whenever either gate-supply rail is undervoltage
module led_driver_fault_supervisor (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enableOk,
    input  wire logic gateSupplyRailOk,
    input  wire logic externalGateSupplyRailOk,
    input  wire logic overTempShutdown,
    input  wire logic outputFeedbackBelowShort,
    input  wire logic outputFeedbackAboveOv,
    input  wire logic outputFeedbackAboveOpenLoad,
    input  wire logic loadCurrentSenseDiffLow,
    input  wire logic inputOvervoltage,
    input  wire logic softstartAboveBlanking,
    input  wire logic softstartDone,
    input  wire logic regulatorGateDemand,
    output var  logic shortFaultFlagN,
    output var  logic shortFaultFlagOe,
    output var  logic openOvFaultFlagN,
    output var  logic openOvFaultFlagOe,
    output var  logic gateEnable,
    output var  logic gateSupplyEnable,
    output var  logic softstartDischarge,
    output var  logic compDischarge
);
    localparam logic [3:0] SHORT_LIMIT = 4'(fault_supervisor_pkg::SHORT_FILTER_CYCLES);

    logic [8:0] rawIn;
    logic [8:0] syncIn;
    assign rawIn = {enableOk, gateSupplyRailOk, externalGateSupplyRailOk, overTempShutdown,
                    outputFeedbackBelowShort, outputFeedbackAboveOv,
                    outputFeedbackAboveOpenLoad, loadCurrentSenseDiffLow, inputOvervoltage};

    input_sync syncInst (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    // soft-start comparators and regulation demand are on-chip, same clock
    wire enOk      = syncIn[8];
    wire railsOk   = syncIn[7] & syncIn[6];
    wire oTemp     = syncIn[5];
    wire belowShrt = syncIn[4];
    wire outOv     = syncIn[3];
    wire olVolt    = syncIn[2];
    wire olCurr    = syncIn[1];
    wire inOv      = syncIn[0];

    fault_supervisor_pkg::sup_state_t state_reg;
    fault_supervisor_pkg::sup_state_t state_next;
    logic [3:0] shortCnt_reg;
    logic [3:0] shortCnt_next;

    wire active     = (state_reg != fault_supervisor_pkg::ST_IDLE);
    wire blankingOk = softstartAboveBlanking;
    wire openLoad   = active & blankingOk & olVolt & olCurr;
    wire shortSeen  = (shortCnt_reg >= SHORT_LIMIT);
    wire shortFault = active & shortSeen;
    wire ovFault    = active & (outOv | inOv | openLoad);

    // short counter only runs once the ramp is past blanking
    always_comb begin
        shortCnt_next = SHORT_CNT_RST();
        if (active && blankingOk && belowShrt) begin
            shortCnt_next = shortSeen ? shortCnt_reg : shortCnt_reg + 4'h1;
        end
    end

    function automatic logic [3:0] SHORT_CNT_RST();
        return fault_supervisor_pkg::SHORT_CNT_RESET;
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fault_supervisor_pkg::ST_IDLE: begin
                if (enOk && railsOk && !oTemp) begin
                    state_next = fault_supervisor_pkg::ST_SOFT;
                end
            end
            fault_supervisor_pkg::ST_SOFT, fault_supervisor_pkg::ST_RUN: begin
                if (shortCnt_next >= SHORT_LIMIT) begin
                    state_next = fault_supervisor_pkg::ST_SHORT;
                end else if (outOv || inOv || openLoad) begin
                    state_next = fault_supervisor_pkg::ST_OPENOV;
                end else if (state_reg == fault_supervisor_pkg::ST_SOFT && softstartDone) begin
                    state_next = fault_supervisor_pkg::ST_RUN;
                end
            end
            fault_supervisor_pkg::ST_SHORT: begin
                if (!belowShrt) begin
                    state_next = fault_supervisor_pkg::ST_SOFT;
                end
            end
            fault_supervisor_pkg::ST_OPENOV: begin
                // restart through soft start only once all three causes have cleared
                if (!outOv && !inOv && !(olVolt && olCurr)) begin
                    state_next = fault_supervisor_pkg::ST_SOFT;
                end
            end
            fault_supervisor_pkg::ST_OTEMP: begin
                if (!oTemp) begin
                    state_next = fault_supervisor_pkg::ST_IDLE;
                end
            end
            default: state_next = fault_supervisor_pkg::ST_IDLE;
        endcase
        // overtemperature overrules everything, undervoltage drops to idle
        if (oTemp) begin
            state_next = fault_supervisor_pkg::ST_OTEMP;
        end else if (!enOk || !railsOk) begin
            state_next = fault_supervisor_pkg::ST_IDLE;
        end
    end

    wire inOtemp   = (state_next == fault_supervisor_pkg::ST_OTEMP);
    wire inShort   = (state_next == fault_supervisor_pkg::ST_SHORT);
    wire inOpenOv  = (state_next == fault_supervisor_pkg::ST_OPENOV);
    wire switching = (state_next == fault_supervisor_pkg::ST_SOFT)
                   | (state_next == fault_supervisor_pkg::ST_RUN);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg          <= fault_supervisor_pkg::ST_IDLE;
            shortCnt_reg       <= fault_supervisor_pkg::SHORT_CNT_RESET;
            shortFaultFlagN    <= fault_supervisor_pkg::FLAG_RELEASED;
            shortFaultFlagOe   <= 1'b0;
            openOvFaultFlagN   <= fault_supervisor_pkg::FLAG_RELEASED;
            openOvFaultFlagOe  <= 1'b0;
            gateEnable         <= 1'b0;
            gateSupplyEnable   <= 1'b0;
            softstartDischarge <= 1'b1;
            compDischarge      <= 1'b0;
        end else begin
            state_reg          <= state_next;
            shortCnt_reg       <= shortCnt_next;
            shortFaultFlagN    <= !(inOtemp | inShort);
            shortFaultFlagOe   <= inOtemp | inShort;
            openOvFaultFlagN   <= !(inOtemp | inOpenOv);
            openOvFaultFlagOe  <= inOtemp | inOpenOv;
            gateEnable         <= switching & railsOk & regulatorGateDemand;
            gateSupplyEnable   <= !inOtemp;
            softstartDischarge <= !switching;
            compDischarge      <= inOpenOv & olVolt & olCurr;
        end
    end

    // ---------------- assertions
    short_filter_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state_reg == fault_supervisor_pkg::ST_SHORT) |-> shortCnt_reg == SHORT_LIMIT)
        else $error("short declared without full filter");
    short_blank_a: assert property (@(posedge clk) disable iff (rst)
        !blankingOk |=> shortCnt_reg == 4'h0)
        else $error("short counted during blanking");
    short_flags_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == fault_supervisor_pkg::ST_SHORT |-> !shortFaultFlagN && openOvFaultFlagN
        && !gateEnable && gateSupplyEnable)
        else $error("short outputs wrong");
    openov_flags_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == fault_supervisor_pkg::ST_OPENOV |-> shortFaultFlagN && !openOvFaultFlagN
        && !gateEnable && softstartDischarge)
        else $error("open or overvoltage outputs wrong");
    otemp_flags_a: assert property (@(posedge clk) disable iff (rst)
        oTemp |=> state_reg == fault_supervisor_pkg::ST_OTEMP && !shortFaultFlagN
        && !openOvFaultFlagN && !gateSupplyEnable)
        else $error("overtemperature not dominant");
    idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == fault_supervisor_pkg::ST_IDLE |-> shortFaultFlagN && openOvFaultFlagN
        && !gateEnable)
        else $error("fault reported while idle");
    rail_gate_a: assert property (@(posedge clk) disable iff (rst)
        !railsOk |=> !gateEnable)
        else $error("gates on with rail low");
    comp_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == fault_supervisor_pkg::ST_OPENOV && $past(olVolt && olCurr) |-> compDischarge)
        else $error("comp not discharged in open load");
    short_restart_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == fault_supervisor_pkg::ST_SHORT && !belowShrt && !oTemp && enOk && railsOk
        |=> state_reg == fault_supervisor_pkg::ST_SOFT)
        else $error("no soft start after short");

    short_c: cover property (@(posedge clk) state_reg == fault_supervisor_pkg::ST_SHORT);
    openov_c: cover property (@(posedge clk) state_reg == fault_supervisor_pkg::ST_OPENOV);
    otemp_c: cover property (@(posedge clk) state_reg == fault_supervisor_pkg::ST_OTEMP);
    run_c: cover property (@(posedge clk) state_reg == fault_supervisor_pkg::ST_RUN);
endmodule
`default_nettype wire

// ### pkg/fault_supervisor_pkg.sv
// shared constants and state codes for the led driver fault supervisor
`default_nettype none
package fault_supervisor_pkg;
    localparam int          SHORT_FILTER_CYCLES = 8;
    localparam logic [3:0]  SHORT_CNT_RESET     = 4'h0;
    localparam int          SYNC_WIDTH          = 9;
    localparam logic [8:0]  SYNC_RESET          = 9'h000;
    localparam logic        FLAG_RELEASED       = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SOFT   = 3'b001,
        ST_RUN    = 3'b010,
        ST_SHORT  = 3'b011,
        ST_OPENOV = 3'b100,
        ST_OTEMP  = 3'b101
    } sup_state_t;
endpackage
`default_nettype wire

// ### test/host_flag_reader.sv
// host-side model that decodes the two pulled-up fault lines
`timescale 1ns/1ns
`default_nettype none
module host_flag_reader (
    input  wire logic       shortLine,
    input  wire logic       openOvLine,
    output var  logic [1:0] faultClass
);
    // 0 none, 1 short, 2 open load or overvoltage, 3 overtemperature
    always_comb begin
        case ({shortLine, openOvLine})
            2'h0:    faultClass = 2'h3;
            2'h1:    faultClass = 2'h1;
            2'h2:    faultClass = 2'h2;
            default: faultClass = 2'h0;
        endcase
    end
endmodule
`default_nettype wire

// ### test/tb_led_driver_fault_supervisor.sv
// self-checking bench for the fault supervisor with a host flag reader
`timescale 1ns/1ns
`default_nettype none
module tb_led_driver_fault_supervisor;
    logic clk = 1'h0, rst = 1'h1, enableOk = 1'h0, gateSupplyRailOk = 1'h1;
    logic externalGateSupplyRailOk = 1'h1, overTempShutdown = 1'h0;
    logic outputFeedbackBelowShort = 1'h0, outputFeedbackAboveOv = 1'h0;
    logic outputFeedbackAboveOpenLoad = 1'h0, loadCurrentSenseDiffLow = 1'h0;
    logic inputOvervoltage = 1'h0, softstartAboveBlanking = 1'h0, softstartDone = 1'h0;
    logic regulatorGateDemand = 1'h0;
    logic shortFaultFlagN, shortFaultFlagOe, openOvFaultFlagN, openOvFaultFlagOe;
    logic gateEnable, gateSupplyEnable, softstartDischarge, compDischarge;
    logic [1:0] faultClass;
    logic [13:0] pend[$];
    int bad_count = 0, tests_run = 0, k;
    event sampleEv;
    // both flag pins are open drain with a pull-up on the board
    wire logic shortLine  = shortFaultFlagOe ? shortFaultFlagN : 1'h1;
    wire logic openOvLine = openOvFaultFlagOe ? openOvFaultFlagN : 1'h1;
    wire logic [5:0] outVec = {shortLine, openOvLine, gateEnable, gateSupplyEnable,
                               softstartDischarge, compDischarge};
    led_driver_fault_supervisor led_driver_fault_supervisor_inst (.clk(clk), .rst(rst),
        .enableOk(enableOk), .gateSupplyRailOk(gateSupplyRailOk),
        .externalGateSupplyRailOk(externalGateSupplyRailOk),
        .overTempShutdown(overTempShutdown), .outputFeedbackBelowShort(outputFeedbackBelowShort),
        .outputFeedbackAboveOv(outputFeedbackAboveOv),
        .outputFeedbackAboveOpenLoad(outputFeedbackAboveOpenLoad),
        .loadCurrentSenseDiffLow(loadCurrentSenseDiffLow), .inputOvervoltage(inputOvervoltage),
        .softstartAboveBlanking(softstartAboveBlanking), .softstartDone(softstartDone),
        .regulatorGateDemand(regulatorGateDemand), .shortFaultFlagN(shortFaultFlagN),
        .shortFaultFlagOe(shortFaultFlagOe), .openOvFaultFlagN(openOvFaultFlagN),
        .openOvFaultFlagOe(openOvFaultFlagOe), .gateEnable(gateEnable),
        .gateSupplyEnable(gateSupplyEnable), .softstartDischarge(softstartDischarge),
        .compDischarge(compDischarge));
    host_flag_reader host_flag_reader_inst (.shortLine(shortLine), .openOvLine(openOvLine),
        .faultClass(faultClass));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) regulatorGateDemand <= 1'($urandom);
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmpVec(input logic [5:0] got, input logic [5:0] want, input logic [5:0] m);
        tests_run++;
        if ((got & m) !== (want & m)) begin
            bad_count++;
            $display("unexpected at %0t: outputs %b want %b", $time, got & m, want & m);
        end
    endtask
    task automatic cmpClass(input logic [1:0] got, input logic [1:0] want);
        tests_run++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: host class %0d want %0d", $time, got, want);
        end
    endtask
    // monitor side: each sample request takes the oldest note
    initial begin
        logic [13:0] e;
        forever begin
            @(sampleEv);
            e = pend.pop_front();
            cmpVec(outVec, e[7:2], e[13:8]);
            cmpClass(faultClass, e[1:0]);
        end
    end
    task automatic note(input logic [5:0] m, input logic [5:0] v, input logic [1:0] c);
        pend.push_back({m, v, c});
        ->sampleEv;
    endtask
    // async inputs need three edges; six leaves margin and stays settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic waitRun();
        for (int i = 0; i < 60 && gateEnable !== 1'h1; i++) @(negedge clk);
        if (gateEnable !== 1'h1) begin
            bad_count++;
            $display("unexpected at %0t: gates never enabled", $time);
            summarize();
        end
    endtask
    initial begin
        void'($urandom(32'h05FF));
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        outputFeedbackBelowShort <= 1'h1;
        inputOvervoltage <= 1'h1;
        settle(8);
        note(6'h38, 6'h30, 2'h0);
        @(posedge clk);
        {inputOvervoltage, enableOk, outputFeedbackAboveOpenLoad} <= 3'h3;
        loadCurrentSenseDiffLow <= 1'h1;
        settle(20);
        note(6'h32, 6'h30, 2'h0);
        @(posedge clk);
        {outputFeedbackBelowShort, outputFeedbackAboveOpenLoad} <= 2'h0;
        {softstartAboveBlanking, softstartDone} <= 2'h3;
        waitRun();
        note(6'h3F, 6'h3C, 2'h0);
        @(posedge clk);
        outputFeedbackBelowShort <= 1'h1;
        repeat (7) @(posedge clk);
        outputFeedbackBelowShort <= 1'h0;
        settle(6);
        // gate bit masked: demand is random and only waitRun waits for a cycle with it high
        note(6'h37, 6'h34, 2'h0);
        @(posedge clk);
        {outputFeedbackBelowShort, softstartDone} <= 2'h2;
        settle(12 + $urandom % 4);
        note(6'h3F, 6'h16, 2'h1);
        @(posedge clk);
        outputFeedbackBelowShort <= 1'h0;
        settle(6);
        note(6'h32, 6'h30, 2'h0);
        @(posedge clk);
        softstartDone <= 1'h1;
        waitRun();
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            {outputFeedbackAboveOv, inputOvervoltage} <= {k == 0, k == 1};
            {outputFeedbackAboveOpenLoad, loadCurrentSenseDiffLow} <= {2{k == 2}};
            settle(6);
            note(6'h3F, {5'h13, k == 2}, 2'h2);
            @(posedge clk);
            {outputFeedbackAboveOv, inputOvervoltage, outputFeedbackAboveOpenLoad} <= 3'h0;
            loadCurrentSenseDiffLow <= 1'h0;
            settle(2);
            waitRun();
            note(6'h3F, 6'h3C, 2'h0);
        end
        @(posedge clk);
        outputFeedbackAboveOpenLoad <= 1'h1;
        settle(6);
        note(6'h37, 6'h34, 2'h0);
        @(posedge clk);
        {outputFeedbackAboveOpenLoad, outputFeedbackBelowShort, overTempShutdown} <= 3'h3;
        settle(14);
        note(6'h3C, 6'h00, 2'h3);
        @(posedge clk);
        {outputFeedbackBelowShort, overTempShutdown} <= 2'h0;
        settle(2);
        waitRun();
        note(6'h3C, 6'h3C, 2'h0);
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            {gateSupplyRailOk, externalGateSupplyRailOk} <= {k == 1, k == 0};
            settle(6);
            note(6'h08, 6'h00, 2'h0);
            @(posedge clk);
            {gateSupplyRailOk, externalGateSupplyRailOk} <= 2'h3;
            settle(2);
            waitRun();
        end
        settle(2);
        summarize();
    end
endmodule
`default_nettype wire
